/* File: shared/vsq_pkg.sv */
// Constants, types and lookup table for the start-up sequencer core.
// Assumes a 25 MHz pclk; all timing counts derive from CLK_MHZ.
package vsq_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int CLK_MHZ        = 25;
	localparam int SS_DELAY_US    = 100;
	localparam int SS_DELAY_CYC   = SS_DELAY_US * CLK_MHZ;
	localparam int AF_PERIOD_US   = 35;
	localparam int AF_PERIOD_CYC  = AF_PERIOD_US * CLK_MHZ;
	localparam int PG_SW_CYCLES   = 13;
	localparam int DEM_RUN_LEN    = 3;
	localparam int CNT_W          = 12;

	////////////////////////////////////////////////////////////////////////////////
	// APB map (byte addresses)
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_SETPOINT = 8'h08;
	localparam logic [7:0] OFS_TARGET   = 8'h0c;
	localparam int         CTRL_FORCE_CCM = 0;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// Set-point table, units of 10 uV, index = voltage code
	localparam int SP_W = 17;
	localparam logic [SP_W-1:0] CODE_TARGET [32] = '{
		17'h1f6ee, 17'h1ecdf, 17'h1e2d0, 17'h1d8c1, 17'h1ceb2, 17'h1c4a3, 17'h1ba94, 17'h1b085,
		17'h1a676, 17'h19c67, 17'h19258, 17'h18849, 17'h17e3a, 17'h1742b, 17'h16a1c, 17'h1600d,
		17'h155fe, 17'h14bef, 17'h141e0, 17'h137d1, 17'h12dc2, 17'h123b3, 17'h119a4, 17'h10f95,
		17'h10586, 17'h0fb77, 17'h0f168, 17'h0e759, 17'h0dd4a, 17'h0d33b, 17'h0c92c, 17'h0a0f0
	};
	localparam logic [SP_W-1:0] SP_ZERO = 17'h00000;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [4:0] {
		ST_OFF   = 5'b00001,
		ST_DELAY = 5'b00010,
		ST_RAMP  = 5'b00100,
		ST_COUNT = 5'b01000,
		ST_GOOD  = 5'b10000
	} vsq_state_t;

	typedef enum logic [1:0] {
		WIN_NOM = 2'h0,
		WIN_130 = 2'h1,
		WIN_150 = 2'h2
	} vsq_window_t;

	typedef struct packed {
		logic        dem_allowed;
		vsq_window_t window;
		logic        audio_filter;
	} vsq_mode_t;

	typedef struct packed {
		logic [17:0] rsvd;
		logic        audio_active;
		vsq_window_t window;
		logic        diode_emulation;
		logic        gpu_mode2;
		logic        power_good;
		logic [2:0]  pad;
		vsq_state_t  state;
	} vsq_status_t;

endpackage : vsq_pkg

/* File: hw/vsq_sync.sv */
// Three-flop pin synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk; output changes when stages 2 and 3 agree.
`timescale 1ns/1ps
module vsq_sync #(
	parameter int          W     = 1,
	parameter logic [W-1:0] RST_V = '0
) (
	input  wire logic         clk,     // Sampling clock
	input  wire logic         rst_n,   // Async reset, active low
	input  wire logic [W-1:0] d,       // Asynchronous input
	output logic      [W-1:0] q        // Filtered, synchronous output
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= RST_V;
			s2_r <= RST_V;
			s3_r <= RST_V;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Per bit, take the new value only once stages 2 and 3 agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= RST_V;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					q[i] <= s3_r[i];
				end
			end
		end
	end

endmodule : vsq_sync

/* File: hw/vsq_core.sv */
// Digital sequencing core of a single-phase buck regulator.
// Assumes analog comparators supply supply-ok, in-window, phase polarity and PWM request.
// What this block does
// - Five code inputs form one word, input 0 least significant.
// - Code maps to target via fixed table, zero highest, all-ones lowest.
// - Code MSB clear is mode 1, set is mode 2; set-point zero when disabled.
// - Enable input high converts, low disables; device follows the level.
// - Disabled until supply ok; disabled again when supply drops, whatever enable says.
// - After supply ok and enable, wait 100 us, then ramp set-point.
// - Within 10% of target, count 13 switching cycles, then release power-good.
// - During soft-start force continuous conduction, ignoring mode selects.
// - Power-good is open drain, low unless regulation is available.
// - Emulation and audio filter chosen from filter select, forced select, mode.
// - Switch-node polarity is sampled to decide emulation entry and exit.
// - Mode 1: forced 0 off/nominal, 1 on/130%; mode 2: filter 0 150%, 1 130%.
// - Three negative-current pulses enter emulation; three positive pulses leave.
// - Audio filter pulses low-side gate about every 35 us.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
module vsq_core
	import vsq_pkg::*;
#(
	parameter int SS_STEP   = 1,  // Set-point ramp step per clock, 10 uV units
	parameter int BLANK_CYC = 2,  // Phase blanking after low interval start
	parameter int AF_ON_CYC = 4   // Low-side width of an audio-filter pulse
) (
	input  wire logic                      pclk,                    // Clock, 25 MHz
	input  wire logic                      presetn,                 // Async reset, low
	input  wire logic                      psel,                    // APB select
	input  wire logic                      penable,                 // APB enable
	input  wire logic                      pwrite,                  // APB direction
	input  wire logic [7:0]                paddr,                   // APB byte address
	input  wire logic [31:0]               pwdata,                  // APB write data
	output logic      [31:0]               prdata,                  // APB read data
	output logic                           pready,                  // APB ready
	output logic                           pslverr,                 // APB error
	input  wire logic                      regulator_enable_in,     // Conversion enable pin
	input  wire logic [4:0]                voltage_code_in,         // Voltage code pins
	input  wire logic                      forced_emulation_select, // Forced select pin
	input  wire logic                      audio_filter_select,     // Filter select pin
	input  wire logic                      supply_ok_in,            // Supply above reset
	input  wire logic                      output_in_window_in,     // Output within 10%
	input  wire logic                      phase_positive_in,       // Switch node above ground
	input  wire logic                      pwm_request_in,          // Modulator high-side request
	output logic                           high_side_gate,          // High-side drive
	output logic                           low_side_gate,           // Low-side drive
	output logic                           power_good_out_o,        // Open-drain data, 0
	output logic                           power_good_out_oe_n,     // Pull low when 0
	output logic      [vsq_pkg::SP_W-1:0]  setpoint_out,            // Set-point, 10 uV
	output logic                           gpu_mode2_out,           // Mode 2 decoded
	output logic                           diode_emulation,         // Emulation active
	output logic                           continuous_conduction,   // Sync rectification
	output vsq_pkg::vsq_window_t           window_out,              // Window step
	output logic                           audio_filter_active      // Filter armed
);
	import vsq_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [11:0] pins_s;
	logic        en_s;
	logic [4:0]  code_s;
	logic        fde_s;
	logic        afs_s;
	logic        sup_s;
	logic        win_s;
	logic        ph_s;
	logic        pwm_s;

	vsq_sync #(.W(12), .RST_V(12'h000)) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({regulator_enable_in, voltage_code_in, forced_emulation_select,
		         audio_filter_select, supply_ok_in, output_in_window_in,
		         phase_positive_in, pwm_request_in}),
		.q     (pins_s)
	);

	assign {en_s, code_s, fde_s, afs_s, sup_s, win_s, ph_s, pwm_s} = pins_s;

	////////////////////////////////////////////////////////////////////////////////
	// Decode
	logic [SP_W-1:0] target;
	logic            mode2;
	logic            run_ok;
	vsq_mode_t       sel;

	assign target = CODE_TARGET[code_s];
	assign mode2  = code_s[4];
	assign run_ok = sup_s && en_s;

	always_comb begin
		sel = '{dem_allowed: 1'b0, window: WIN_NOM, audio_filter: 1'b0};
		if (!mode2) begin
			if (fde_s) begin
				sel = '{dem_allowed: 1'b1, window: WIN_130, audio_filter: 1'b0};
			end
		end else if (!afs_s) begin
			sel = '{dem_allowed: 1'b1, window: WIN_150, audio_filter: 1'b0};
		end else begin
			sel = '{dem_allowed: 1'b1, window: WIN_130, audio_filter: !fde_s};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	vsq_state_t      state_r;
	vsq_state_t      state_nxt;
	logic [CNT_W-1:0] dly_r;
	logic [3:0]      sw_cnt_r;
	logic            pwm_q_r;
	logic            pwm_rise;
	logic            switching;

	assign pwm_rise  = pwm_s && !pwm_q_r;
	assign switching = (state_r == ST_RAMP) || (state_r == ST_COUNT) || (state_r == ST_GOOD);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF:   if (run_ok) state_nxt = ST_DELAY;
			ST_DELAY: if (dly_r == CNT_W'(SS_DELAY_CYC - 1)) state_nxt = ST_RAMP;
			ST_RAMP:  if (win_s) state_nxt = ST_COUNT;
			ST_COUNT: if (pwm_rise && sw_cnt_r == 4'(PG_SW_CYCLES - 1)) state_nxt = ST_GOOD;
			ST_GOOD:  state_nxt = ST_GOOD;
			default:  state_nxt = ST_OFF;
		endcase
		if (!run_ok) begin
			state_nxt = ST_OFF;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Delay and switching-cycle counters restart from zero on every entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_r    <= '0;
			sw_cnt_r <= 4'h0;
			pwm_q_r  <= 1'b0;
		end else begin
			pwm_q_r <= pwm_s;
			if (state_r == ST_DELAY && state_nxt == ST_DELAY) begin
				dly_r <= dly_r + CNT_W'(1);
			end else begin
				dly_r <= '0;
			end
			if (state_r == ST_COUNT && state_nxt == ST_COUNT) begin
				sw_cnt_r <= sw_cnt_r + (pwm_rise ? 4'h1 : 4'h0);
			end else begin
				sw_cnt_r <= 4'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Set-point: ramp during soft-start, track directly once good
	logic [SP_W-1:0] sp_nxt;

	always_comb begin
		sp_nxt = setpoint_out;
		case (state_r)
			ST_OFF, ST_DELAY: sp_nxt = SP_ZERO;
			ST_RAMP, ST_COUNT: begin
				if (setpoint_out + SP_W'(SS_STEP) < target) begin
					sp_nxt = setpoint_out + SP_W'(SS_STEP);
				end else begin
					sp_nxt = target;
				end
			end
			ST_GOOD:  sp_nxt = target;
			default:  sp_nxt = SP_ZERO;
		endcase
		if (!run_ok) begin
			sp_nxt = SP_ZERO;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setpoint_out  <= SP_ZERO;
			gpu_mode2_out <= 1'b0;
		end else begin
			setpoint_out  <= sp_nxt;
			gpu_mode2_out <= mode2;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power-good open drain: drive low except in the good state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_good_out_o    <= 1'b0;
			power_good_out_oe_n <= 1'b0;
		end else begin
			power_good_out_o    <= 1'b0;
			power_good_out_oe_n <= (state_nxt == ST_GOOD) ? 1'b1 : 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Phase polarity per pulse and emulation entry/exit
	logic [1:0] blank_r;
	logic       ph_latch_r;
	logic [1:0] neg_run_r;
	logic [1:0] pos_run_r;
	logic       dem_r;
	logic       force_ccm_r;
	logic       dem_ok;

	assign dem_ok = (state_r == ST_GOOD) && sel.dem_allowed && !force_ccm_r;

	// Positive phase while high side is off means negative inductor current
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blank_r    <= 2'h0;
			ph_latch_r <= 1'b0;
		end else if (pwm_s || !switching) begin
			blank_r    <= 2'h0;
			ph_latch_r <= 1'b0;
		end else begin
			if (blank_r != 2'(BLANK_CYC)) begin
				blank_r <= blank_r + 2'h1;
			end else if (ph_s) begin
				ph_latch_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			neg_run_r <= 2'h0;
			pos_run_r <= 2'h0;
			dem_r     <= 1'b0;
		end else if (!dem_ok) begin
			neg_run_r <= 2'h0;
			pos_run_r <= 2'h0;
			dem_r     <= 1'b0;
		end else if (pwm_rise) begin
			if (ph_latch_r) begin
				pos_run_r <= 2'h0;
				if (neg_run_r == 2'(DEM_RUN_LEN - 1)) begin
					dem_r     <= 1'b1;
					neg_run_r <= 2'h0;
				end else begin
					neg_run_r <= neg_run_r + 2'h1;
				end
			end else begin
				neg_run_r <= 2'h0;
				if (pos_run_r == 2'(DEM_RUN_LEN - 1)) begin
					dem_r     <= 1'b0;
					pos_run_r <= 2'h0;
				end else begin
					pos_run_r <= pos_run_r + 2'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Audio filter: low-side kick after 35 us without one
	logic [CNT_W-1:0] af_cnt_r;
	logic [2:0]       af_on_r;
	logic             af_arm;
	logic             ls_natural;

	assign af_arm     = dem_r && sel.audio_filter;
	assign ls_natural = switching && !pwm_s && !(dem_r && ph_latch_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			af_cnt_r <= '0;
			af_on_r  <= 3'h0;
		end else if (!af_arm || pwm_s) begin
			af_cnt_r <= '0;
			af_on_r  <= 3'h0;
		end else if (af_on_r != 3'h0) begin
			af_on_r  <= af_on_r - 3'h1;
			af_cnt_r <= '0;
		end else if (ls_natural && !ph_latch_r) begin
			af_cnt_r <= '0;
		end else if (af_cnt_r == CNT_W'(AF_PERIOD_CYC - 1)) begin
			af_cnt_r <= '0;
			af_on_r  <= 3'(AF_ON_CYC);
		end else begin
			af_cnt_r <= af_cnt_r + CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Gate drives and mode outputs, all off while disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_side_gate        <= 1'b0;
			low_side_gate         <= 1'b0;
			diode_emulation       <= 1'b0;
			continuous_conduction <= 1'b0;
			window_out            <= WIN_NOM;
			audio_filter_active   <= 1'b0;
		end else if (!run_ok || !switching) begin
			high_side_gate        <= 1'b0;
			low_side_gate         <= 1'b0;
			diode_emulation       <= 1'b0;
			continuous_conduction <= 1'b0;
			window_out            <= WIN_NOM;
			audio_filter_active   <= 1'b0;
		end else begin
			high_side_gate        <= pwm_s;
			low_side_gate         <= ls_natural || (af_on_r != 3'h0);
			diode_emulation       <= dem_r;
			continuous_conduction <= !dem_r;
			window_out            <= dem_r ? sel.window : WIN_NOM;
			audio_filter_active   <= af_arm;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB slave, one wait state per access
	logic        acc;
	logic        hit;
	logic [31:0] rd_mux;
	vsq_status_t sts;

	assign acc = psel && penable;

	always_comb begin
		sts                 = '0;
		sts.state           = state_r;
		sts.power_good      = power_good_out_oe_n;
		sts.gpu_mode2       = gpu_mode2_out;
		sts.diode_emulation = diode_emulation;
		sts.window          = window_out;
		sts.audio_active    = audio_filter_active;
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			OFS_CTRL:     rd_mux = {31'h0000_0000, force_ccm_r};
			OFS_STATUS:   rd_mux = sts;
			OFS_SETPOINT: rd_mux = {15'h0000, setpoint_out};
			OFS_TARGET:   rd_mux = {15'h0000, target};
			default:      hit    = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= acc && !pready;
			prdata  <= (acc && !pready && !pwrite && hit) ? rd_mux : 32'h0000_0000;
			pslverr <= acc && !pready && !hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_ccm_r <= CTRL_RESET[CTRL_FORCE_CCM];
		end else if (acc && pready && pwrite && paddr == OFS_CTRL) begin
			force_ccm_r <= pwdata[CTRL_FORCE_CCM];
		end
	end

endmodule : vsq_core

/* File: bench/vsq_core_props.sv */
// Concurrent checks on the pins of the start-up sequencer core.
// Assumes it is bound to vsq_core and sees only that module's ports.
`timescale 1ns/1ps
module vsq_core_props
	import vsq_pkg::*;
#(
	parameter int SS_STEP = 1 // Ramp step per clock
) (
	input wire logic                    pclk,                    // Clock
	input wire logic                    presetn,                 // Reset, low
	input wire logic                    regulator_enable_in,     // Enable pin
	input wire logic [4:0]              voltage_code_in,         // Code pins
	input wire logic                    forced_emulation_select, // Forced select
	input wire logic                    supply_ok_in,            // Supply ok
	input wire logic                    high_side_gate,          // High-side drive
	input wire logic                    low_side_gate,           // Low-side drive
	input wire logic                    power_good_out_o,        // Open-drain data
	input wire logic                    power_good_out_oe_n,     // Pull-low enable
	input wire logic [vsq_pkg::SP_W-1:0] setpoint_out,           // Set-point
	input wire logic                    gpu_mode2_out,           // Mode 2
	input wire logic                    diode_emulation,         // Emulation
	input wire vsq_pkg::vsq_window_t    window_out,              // Window step
	input wire logic                    audio_filter_active      // Filter armed
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////////////
	// Input histories long enough to pass the pin synchronisers
	sequence en_off;
		!regulator_enable_in [*8];
	endsequence
	sequence sup_off;
		!supply_ok_in [*8];
	endsequence
	sequence code_held;
		$stable(voltage_code_in) [*8];
	endsequence
	sequence mode1_fixed;
		(!forced_emulation_select && !voltage_code_in[4]) [*8];
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	pg_data_zero_a: assert property (power_good_out_o == 1'b0)
		else $error("power-good data bit not zero");
	gates_off_a: assert property (en_off |-> !high_side_gate && !low_side_gate
		&& !power_good_out_oe_n && setpoint_out == '0)
		else $error("outputs active while enable low");
	supply_off_a: assert property (sup_off |-> !power_good_out_oe_n
		&& setpoint_out == '0 && !high_side_gate)
		else $error("outputs active while supply low");
	mode_decode_a: assert property (code_held |-> gpu_mode2_out == voltage_code_in[4])
		else $error("mode flag differs from code msb");
	softstart_ccm_a: assert property (!power_good_out_oe_n
		&& !$past(power_good_out_oe_n) |-> !diode_emulation)
		else $error("emulation before power good");
	window_nom_a: assert property (!diode_emulation |-> window_out == WIN_NOM)
		else $error("window widened outside emulation");
	audio_dem_a: assert property (audio_filter_active |-> diode_emulation && gpu_mode2_out)
		else $error("audio filter outside mode 2 emulation");
	mode1_off_a: assert property (mode1_fixed |-> !diode_emulation)
		else $error("emulation in mode 1 without forced select");
	ramp_step_a: assert property (!power_good_out_oe_n && setpoint_out > $past(setpoint_out)
		|-> setpoint_out == $past(setpoint_out) + SP_W'(SS_STEP))
		else $error("set-point ramp step wrong");
endmodule : vsq_core_props

/* File: bench/vsq_ctrl_model.sv */
// Behavioural system controller and analog front end for the core.
// Assumes the bench calls its tasks; every change follows a rising pclk.
`timescale 1ns/1ps
module vsq_ctrl_model (
	input  wire logic  pclk,                    // Core clock
	output logic       regulator_enable_in,     // Enable level
	output logic [4:0] voltage_code_in,         // Code word
	output logic       forced_emulation_select, // Forced select
	output logic       audio_filter_select,     // Filter select
	output logic       supply_ok_in,            // Supply ok
	output logic       output_in_window_in,     // Output in window
	output logic       phase_positive_in,       // Switch node polarity
	output logic       pwm_request_in           // Modulator request
);
	initial begin
		{regulator_enable_in, voltage_code_in, forced_emulation_select} = '0;
		{audio_filter_select, supply_ok_in, output_in_window_in} = '0;
		{phase_positive_in, pwm_request_in} = '0;
	end

	task automatic set_pins(input logic e, s, w, f, a, input logic [4:0] c);
		@(posedge pclk);
		regulator_enable_in <= e;
		supply_ok_in <= s;
		output_in_window_in <= w;
		forced_emulation_select <= f;
		audio_filter_select <= a;
		voltage_code_in <= c;
	endtask : set_pins

	// One switching cycle; negative current shows as a positive phase when low
	task automatic pulse(input logic neg);
		@(posedge pclk);
		pwm_request_in <= 1'b1;
		phase_positive_in <= 1'b1;
		repeat (4) @(posedge pclk);
		pwm_request_in <= 1'b0;
		phase_positive_in <= neg;
		repeat (8) @(posedge pclk);
	endtask : pulse
endmodule : vsq_ctrl_model

/* File: bench/vsq_core_test.sv */
// Self-checking bench for the sequencer core: APB, decode, start-up, modes.
// Assumes vsq_ctrl_model drives the pins and vsq_core_props is bound below.
`timescale 1ns/1ps
module vsq_core_test;
	import vsq_pkg::*;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0, prdata, rd;
	logic              pready, pslverr, err, regulator_enable_in, supply_ok_in;
	logic              forced_emulation_select, audio_filter_select, output_in_window_in;
	logic              phase_positive_in, pwm_request_in, high_side_gate, low_side_gate;
	logic              power_good_out_o, power_good_out_oe_n, gpu_mode2_out;
	logic              diode_emulation, continuous_conduction, audio_filter_active;
	logic [4:0]        voltage_code_in, code;
	logic [SP_W-1:0]   setpoint_out;
	vsq_window_t       window_out;
	int                bad_count = 0, compares = 0, n, i;

	always #20 pclk = ~pclk;

	vsq_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .regulator_enable_in, .voltage_code_in, .forced_emulation_select,
		.audio_filter_select, .supply_ok_in, .output_in_window_in, .phase_positive_in,
		.pwm_request_in, .high_side_gate, .low_side_gate, .power_good_out_o,
		.power_good_out_oe_n, .setpoint_out, .gpu_mode2_out, .diode_emulation,
		.continuous_conduction, .window_out, .audio_filter_active);
	vsq_ctrl_model ctl (.pclk, .regulator_enable_in, .voltage_code_in,
		.forced_emulation_select, .audio_filter_select, .supply_ok_in,
		.output_in_window_in, .phase_positive_in, .pwm_request_in);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [SP_W-1:0] exp_tgt(input int c);
		return (c == 31) ? 17'h0a0f0 : 17'h1f6ee - 17'(c) * 17'h00a0f;
	endfunction : exp_tgt
	function automatic vsq_window_t exp_win(input int k);
		if (!k[2] && !k[1])
			return WIN_NOM;
		return (k[2] && !k[0]) ? WIN_150 : WIN_130;
	endfunction : exp_win

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic complete_run();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic bounded(input int cnt, input int lim);
		if (cnt >= lim) begin
			bad_count++;
			complete_run();
		end
	endtask : bounded
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		bounded(n, 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h9cc25d0e));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		chk(power_good_out_oe_n, 0);
		apb(0, OFS_CTRL, 0);
		chk(rd, CTRL_RESET);
		apb(1, OFS_CTRL, 1);
		apb(0, OFS_CTRL, 0);
		chk(rd, 1);
		apb(1, OFS_CTRL, 0);
		apb(0, 8'h40, 0);
		chk(err, 1);
		for (i = 0; i < 32; i++) begin
			ctl.set_pins(0, 1, 0, 0, 0, 5'(i));
			repeat (6) @(posedge pclk);
			apb(0, OFS_TARGET, 0);
			chk(rd, exp_tgt(i));
			chk(gpu_mode2_out, i >= 16);
			chk(setpoint_out, 0);
		end
		ctl.set_pins(1, 0, 0, 1, 0, 5'h1f);
		repeat (3000) @(posedge pclk);
		chk(setpoint_out, 0);
		ctl.set_pins(1, 1, 0, 1, 0, 5'h1f);
		repeat (2500) @(posedge pclk);
		chk(setpoint_out, 0);
		repeat (12) @(posedge pclk);
		chk(setpoint_out != 0, 1);
		n = 0;
		while (setpoint_out !== exp_tgt(31) && n < 4000) begin
			ctl.pulse(1);
			n++;
		end
		bounded(n, 4000);
		ctl.set_pins(1, 1, 1, 1, 0, 5'h1f);
		repeat (8) @(posedge pclk);
		repeat (12) ctl.pulse(0);
		chk(power_good_out_oe_n, 0);
		ctl.pulse(0);
		chk(power_good_out_oe_n, 1);
		for (i = 0; i < 8; i++) begin
			code = {i[2], 4'($urandom)};
			ctl.set_pins(1, 1, 1, i[1], i[0], code);
			repeat (8) @(posedge pclk);
			chk(setpoint_out, exp_tgt(code));
			repeat (4) ctl.pulse(1);
			repeat (6) @(posedge pclk);
			chk(diode_emulation, i[2] | i[1]);
			chk(continuous_conduction, !(i[2] | i[1]));
			chk(window_out, exp_win(i));
			chk(audio_filter_active, i == 5);
			if (i == 5) begin
				n = 0;
				while (low_side_gate !== 1'b1 && n < 1000) begin
					@(posedge pclk);
					n++;
				end
				bounded(n, 1000);
				chk(n > 800, 1);
			end
			repeat (4) ctl.pulse(0);
			repeat (6) @(posedge pclk);
			chk({diode_emulation, continuous_conduction}, 1);
		end
		apb(1, OFS_CTRL, 1);
		repeat (4) ctl.pulse(1);
		repeat (6) @(posedge pclk);
		chk({diode_emulation, continuous_conduction}, 1);
		apb(0, OFS_STATUS, 0);
		chk(rd, {22'h0, 2'b11, 3'h0, ST_GOOD});
		apb(0, OFS_SETPOINT, 0);
		chk(rd, exp_tgt(code));
		apb(1, OFS_CTRL, 0);
		ctl.set_pins(0, 1, 1, 0, 0, 5'h1f);
		repeat (8) @(posedge pclk);
		chk({high_side_gate, low_side_gate, power_good_out_oe_n}, 0);
		chk(setpoint_out, 0);
		ctl.set_pins(1, 0, 1, 0, 0, 5'h1f);
		repeat (8) @(posedge pclk);
		ctl.set_pins(1, 1, 1, 0, 0, 5'h1f);
		repeat (2400) @(posedge pclk);
		chk(setpoint_out, 0);
		complete_run();
	end
endmodule : vsq_core_test

bind vsq_core vsq_core_props #(.SS_STEP(SS_STEP)) u_props (.pclk, .presetn,
	.regulator_enable_in, .voltage_code_in, .forced_emulation_select, .supply_ok_in,
	.high_side_gate, .low_side_gate, .power_good_out_o, .power_good_out_oe_n,
	.setpoint_out, .gpu_mode2_out, .diode_emulation, .window_out, .audio_filter_active);
